/* File: shared/tpb_pkg.sv */
package tpb_pkg;

  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 10;
  localparam int PS_W   = 8;
  localparam int RATE_W = 3;
  localparam int FREQ_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT_LOW  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE   = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO   = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_DUTY_LOW   = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_PS_VALUE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TONE_CTRL  = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_HIGH_BITS  = 8'h19;
  localparam logic [ADDR_W-1:0] OFS_FLAG_CTRL  = 8'h20;

  // Control one fields
  localparam int CTRL1_ENABLE_BIT = 0;
  localparam int CTRL1_RELOAD_BIT = 1;
  localparam int CTRL1_ONESHOT_BIT = 2;
  localparam int CTRL1_PWM_AL_BIT = 6;
  localparam int CTRL1_PWM_OE_BIT = 7;
  localparam logic [DATA_W-1:0] CTRL1_MASK = 8'hc7;
  localparam logic [DATA_W-1:0] CTRL1_RST  = 8'h00;

  // Control two fields
  localparam int CTRL2_RATE_LSB = 0;
  localparam int CTRL2_PSDIS_BIT = 3;
  localparam int CTRL2_EDGE_BIT = 4;
  localparam int CTRL2_SRC_BIT  = 5;
  localparam logic [DATA_W-1:0] CTRL2_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] CTRL2_RST  = 8'h3f;

  // Tone control fields
  localparam int TONE_FREQ_LSB = 0;
  localparam int TONE_EN_BIT   = 7;
  localparam logic [DATA_W-1:0] TONE_MASK = 8'h8f;
  localparam logic [DATA_W-1:0] TONE_RST  = 8'h0f;

  // High bits register fields
  localparam int HIGH_DUTY_LSB   = 0;
  localparam int HIGH_RELOAD_LSB = 4;

  // Flag control fields
  localparam int FLAG_BIT = 0;
  localparam int FLAG_IE_BIT = 1;

  // Reset and wrap values
  localparam logic [PS_W-1:0]   PS_RST     = 8'hff;
  localparam logic [CNT_W-1:0]  CNT_RST    = 10'h000;
  localparam logic [CNT_W-1:0]  CNT_WRAP   = 10'h3ff;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 10'h000;
  localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tpb_bus_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } tpb_pin_t;

endpackage

/* File: src/tpb_prescaler.sv */
`timescale 1ns/1ps
module tpb_prescaler (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       tick,
  input  wire logic [tpb_pkg::RATE_W-1:0] rate_sel,
  input  wire logic [tpb_pkg::RATE_W-1:0] tone_sel,
  output logic      [tpb_pkg::PS_W-1:0]   count_ff,
  output logic                            rate_pulse,
  output logic                            tone_pulse
);
  import tpb_pkg::*;

  logic [PS_W-1:0] rate_mask;
  logic [PS_W-1:0] tone_mask;

  // Tap masks: bits up to the selected code take part, giving 1:2 .. 1:256
  for (genvar i = 0; i < PS_W; i++) begin : g_mask
    assign rate_mask[i] = (RATE_W'(i) <= rate_sel);
    assign tone_mask[i] = (RATE_W'(i) <= tone_sel);
  end

  // Counts down from all ones so the readback starts at the reset value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= PS_RST;
    end else if (tick) begin
      count_ff <= count_ff - 8'h01;
    end
  end

  assign rate_pulse = tick && ((count_ff & rate_mask) == 8'h00);
  assign tone_pulse = tick && ((count_ff & tone_mask) == 8'h00);

endmodule // tpb_prescaler

/* File: src/tpb_timer.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Ten-bit down counter; low count read returns the live count.
// - Low count write loads count from high reload bits and written byte.
// - Counter moves only while the enable bit is set; otherwise holds.
// - Free-running without reload select wraps from zero to 0x3ff.
// - Free-running with reload select reloads programmed value on underflow.
// - One-shot counts once down to zero and stops, ignoring reload select.
// - Polarity bit set makes the PWM output active low.
// - PWM enable puts PWM on the pin; else pin is plain I/O.
// - Three-bit rate gives 1:2 up to 1:256; disable bit bypasses prescaler.
// - Edge bit set counts falling external edges; cleared counts rising.
// - Source bit set selects the external pin, cleared the instruction clock.
// - PWM frame is one full reload count cycle of the timer.
// - Duty is ten bits: duty byte plus high register bits 1:0.
// - Prescaler value register reads the live prescaler count.
// - Tone codes 0 to 7 toggle from prescaler taps 1:2 to 1:256.
// - Tone codes 8 to 15 follow counter bits 0 to 7.
// - Tone enable bit starts the tone output; cleared disables it.
// - High bits 5:4 write reload bits 9:8 and read live count 9:8.
// - Underflow sets a sticky flag; firmware clears; interrupt needs enable.
module tpb_timer (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire tpb_pkg::tpb_bus_req_t      bus_req,
  output logic      [tpb_pkg::DATA_W-1:0] rd_data_ff,
  input  wire logic                       ext_count_clock_pin,
  input  wire logic                       gpio_out,
  input  wire logic                       gpio_oe,
  output tpb_pkg::tpb_pin_t               pwm_pin_ff,
  output logic                            tone_out_ff,
  output logic                            underflow_flag_ff,
  output logic                            underflow_irq_ff
);
  import tpb_pkg::*;

  // Register state
  logic [DATA_W-1:0] ctrl_one_ff;
  logic [DATA_W-1:0] ctrl_two_ff;
  logic [DATA_W-1:0] tone_ctrl_ff;
  logic [CNT_W-1:0]  reload_ff;
  logic [CNT_W-1:0]  duty_ff;
  logic              flag_ie_ff;

  // Counter state
  logic [CNT_W-1:0]  count_ff;
  logic [CNT_W-1:0]  nxt_count;
  logic              stopped_ff;
  logic              ext_prev_ff;
  logic              tone_toggle_ff;

  // Decoded strobes
  logic wr_count_low;
  logic wr_ctrl_one;
  logic wr_ctrl_two;
  logic wr_duty_low;
  logic wr_tone_ctrl;
  logic wr_high_bits;
  logic wr_flag_ctrl;

  // Field views
  logic                 count_enable;
  logic                 reload_select;
  logic                 one_shot_select;
  logic                 pwm_active_low;
  logic                 pwm_output_enable;
  logic [RATE_W-1:0]    prescale_rate_select;
  logic                 prescale_disable_n;
  logic                 ext_edge_select;
  logic                 clock_source_select;
  logic [FREQ_W-1:0]    tone_freq_select;
  logic                 tone_enable;

  // Event path
  logic              ext_rise;
  logic              ext_fall;
  logic              ext_event;
  logic              src_event;
  logic              count_tick;
  logic              underflow;
  logic [PS_W-1:0]   ps_count;
  logic              ps_rate_pulse;
  logic              ps_tone_pulse;
  logic              pwm_level;
  logic              nxt_tone;
  logic [DATA_W-1:0] nxt_rd_data;

  assign wr_count_low = bus_req.wr && (bus_req.addr == OFS_COUNT_LOW);
  assign wr_ctrl_one  = bus_req.wr && (bus_req.addr == OFS_CTRL_ONE);
  assign wr_ctrl_two  = bus_req.wr && (bus_req.addr == OFS_CTRL_TWO);
  assign wr_duty_low  = bus_req.wr && (bus_req.addr == OFS_DUTY_LOW);
  assign wr_tone_ctrl = bus_req.wr && (bus_req.addr == OFS_TONE_CTRL);
  assign wr_high_bits = bus_req.wr && (bus_req.addr == OFS_HIGH_BITS);
  assign wr_flag_ctrl = bus_req.wr && (bus_req.addr == OFS_FLAG_CTRL);

  assign count_enable         = ctrl_one_ff[CTRL1_ENABLE_BIT];
  assign reload_select        = ctrl_one_ff[CTRL1_RELOAD_BIT];
  assign one_shot_select      = ctrl_one_ff[CTRL1_ONESHOT_BIT];
  assign pwm_active_low       = ctrl_one_ff[CTRL1_PWM_AL_BIT];
  assign pwm_output_enable    = ctrl_one_ff[CTRL1_PWM_OE_BIT];
  assign prescale_rate_select = ctrl_two_ff[CTRL2_RATE_LSB +: RATE_W];
  assign prescale_disable_n   = ctrl_two_ff[CTRL2_PSDIS_BIT];
  assign ext_edge_select      = ctrl_two_ff[CTRL2_EDGE_BIT];
  assign clock_source_select  = ctrl_two_ff[CTRL2_SRC_BIT];
  assign tone_freq_select     = tone_ctrl_ff[TONE_FREQ_LSB +: FREQ_W];
  assign tone_enable          = tone_ctrl_ff[TONE_EN_BIT];

  // Control one register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_one_ff <= CTRL1_RST;
    end else if (wr_ctrl_one) begin
      ctrl_one_ff <= bus_req.wdata & CTRL1_MASK;
    end
  end

  // Control two register; the rate is taken as written, firmware keeps
  // the prescaler disabled while changing it to avoid a false underflow
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_two_ff <= CTRL2_RST;
    end else if (wr_ctrl_two) begin
      ctrl_two_ff <= bus_req.wdata & CTRL2_MASK;
    end
  end

  // Tone control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_ctrl_ff <= TONE_RST;
    end else if (wr_tone_ctrl) begin
      tone_ctrl_ff <= bus_req.wdata & TONE_MASK;
    end
  end

  // Reload value: low byte from the count register, top bits from high bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reload_ff <= CNT_RST;
    end else begin
      if (wr_count_low) begin
        reload_ff[7:0] <= bus_req.wdata;
      end
      if (wr_high_bits) begin
        reload_ff[9:8] <= bus_req.wdata[HIGH_RELOAD_LSB +: 2];
      end
    end
  end

  // Ten-bit duty value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duty_ff <= CNT_RST;
    end else begin
      if (wr_duty_low) begin
        duty_ff[7:0] <= bus_req.wdata;
      end
      if (wr_high_bits) begin
        duty_ff[9:8] <= bus_req.wdata[HIGH_DUTY_LSB +: 2];
      end
    end
  end

  // External pin edge detection; the pin is already in the clock domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_count_clock_pin;
    end
  end

  assign ext_rise  = ext_count_clock_pin && !ext_prev_ff;
  assign ext_fall  = !ext_count_clock_pin && ext_prev_ff;
  assign ext_event = ext_edge_select ? ext_fall : ext_rise;
  // Instruction clock is clk itself, so every cycle is an event
  assign src_event = clock_source_select ? ext_event : 1'b1;

  tpb_prescaler u_prescaler (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick       (src_event),
    .rate_sel   (prescale_rate_select),
    .tone_sel   (tone_freq_select[RATE_W-1:0]),
    .count_ff   (ps_count),
    .rate_pulse (ps_rate_pulse),
    .tone_pulse (ps_tone_pulse)
  );

  // Bypass when the active-low enable reads one
  assign count_tick = prescale_disable_n ? src_event : ps_rate_pulse;
  assign underflow  = count_enable && !stopped_ff && count_tick &&
                      (count_ff == CNT_ZERO);

  // Next count
  always_comb begin
    nxt_count = count_ff;
    if (wr_count_low) begin
      nxt_count = {reload_ff[9:8], bus_req.wdata};
    end else if (count_enable && !stopped_ff && count_tick) begin
      if (count_ff != CNT_ZERO) begin
        nxt_count = count_ff - 10'h001;
      end else if (one_shot_select) begin
        nxt_count = CNT_ZERO;
      end else if (reload_select) begin
        nxt_count = reload_ff;
      end else begin
        nxt_count = CNT_WRAP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= CNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // One-shot stop latch; a fresh load or leaving one-shot restarts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stopped_ff <= 1'b0;
    end else if (wr_count_low || !one_shot_select) begin
      stopped_ff <= 1'b0;
    end else if (underflow) begin
      stopped_ff <= 1'b1;
    end
  end

  // Sticky underflow flag; a new underflow beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      underflow_flag_ff <= 1'b0;
    end else if (underflow) begin
      underflow_flag_ff <= 1'b1;
    end else if (wr_flag_ctrl && !bus_req.wdata[FLAG_BIT]) begin
      underflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_ie_ff <= 1'b0;
    end else if (wr_flag_ctrl) begin
      flag_ie_ff <= bus_req.wdata[FLAG_IE_BIT];
    end
  end

  // Interrupt follows the stored flag one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      underflow_irq_ff <= 1'b0;
    end else begin
      underflow_irq_ff <= underflow_flag_ff && flag_ie_ff;
    end
  end

  // Duty compare against the live count gives one pulse per frame
  assign pwm_level = (count_ff < duty_ff) ^ pwm_active_low;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_pin_ff <= '0;
    end else if (pwm_output_enable) begin
      pwm_pin_ff.out <= pwm_level;
      pwm_pin_ff.oe  <= 1'b1;
    end else begin
      pwm_pin_ff.out <= gpio_out;
      pwm_pin_ff.oe  <= gpio_oe;
    end
  end

  // Tone source toggle; held low while disabled so restarts begin clean
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_toggle_ff <= 1'b0;
    end else if (!tone_enable) begin
      tone_toggle_ff <= 1'b0;
    end else if (ps_tone_pulse) begin
      tone_toggle_ff <= !tone_toggle_ff;
    end
  end

  always_comb begin
    nxt_tone = 1'b0;
    if (tone_enable) begin
      if (tone_freq_select[FREQ_W-1]) begin
        nxt_tone = count_ff[tone_freq_select[RATE_W-1:0]];
      end else begin
        nxt_tone = tone_toggle_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_out_ff <= 1'b0;
    end else begin
      tone_out_ff <= nxt_tone;
    end
  end

  // Read mux; write-only and unmapped offsets read zero
  always_comb begin
    nxt_rd_data = READ_ZERO;
    case (bus_req.addr)
      OFS_COUNT_LOW: begin
        nxt_rd_data = count_ff[7:0];
      end
      OFS_CTRL_ONE: begin
        nxt_rd_data = ctrl_one_ff;
      end
      OFS_CTRL_TWO: begin
        nxt_rd_data = ctrl_two_ff;
      end
      OFS_PS_VALUE: begin
        nxt_rd_data = ps_count;
      end
      OFS_HIGH_BITS: begin
        nxt_rd_data[HIGH_RELOAD_LSB +: 2] = count_ff[9:8];
        nxt_rd_data[HIGH_DUTY_LSB +: 2]   = duty_ff[9:8];
      end
      OFS_FLAG_CTRL: begin
        nxt_rd_data[FLAG_BIT]    = underflow_flag_ff;
        nxt_rd_data[FLAG_IE_BIT] = flag_ie_ff;
      end
      default: begin
        nxt_rd_data = READ_ZERO;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff <= READ_ZERO;
    end else if (bus_req.rd) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= READ_ZERO;
    end
  end

endmodule // tpb_timer

/* File: verification/tpb_timer_assertions.sv */
`timescale 1ns/1ps
module tpb_timer_chk (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire tpb_pkg::tpb_bus_req_t      bus_req,
  input wire logic [tpb_pkg::DATA_W-1:0] rd_data_ff,
  input wire logic                       ext_count_clock_pin,
  input wire logic                       gpio_out,
  input wire logic                       gpio_oe,
  input wire tpb_pkg::tpb_pin_t          pwm_pin_ff,
  input wire logic                       tone_out_ff,
  input wire logic                       underflow_flag_ff,
  input wire logic                       underflow_irq_ff
);
  import tpb_pkg::*;
  logic [DATA_W-1:0] c1_ff;
  logic              fclr_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of control one, so readback is judged without the design's state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c1_ff   <= CTRL1_RST;
      fclr_ff <= 1'b0;
    end else begin
      fclr_ff <= bus_req.wr && bus_req.addr == OFS_FLAG_CTRL;
      if (bus_req.wr && bus_req.addr == OFS_CTRL_ONE) c1_ff <= bus_req.wdata;
    end
  end
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data_ff == READ_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero");
  property p_wo_zero;
    $past(bus_req.rd) && ($past(bus_req.addr) == OFS_DUTY_LOW ||
      $past(bus_req.addr) == OFS_TONE_CTRL) |-> rd_data_ff == READ_ZERO;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only read not zero");
  property p_rd_hi;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_HIGH_BITS
      |-> rd_data_ff[7:6] == 2'b00 && rd_data_ff[3:2] == 2'b00;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("high bits spare field set");
  property p_c1_rb;
    $past(bus_req.rd) && $past(bus_req.addr) == OFS_CTRL_ONE
      |-> rd_data_ff == ($past(c1_ff) & CTRL1_MASK);
  endproperty
  a_c1_rb: assert property (p_c1_rb)
    else $error("control one readback wrong");
  property p_irq;
    underflow_irq_ff |-> $past(underflow_flag_ff);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without flag");
  property p_flag_hold;
    $past(underflow_flag_ff) && !fclr_ff |-> underflow_flag_ff;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");
  property p_pin_gpio;
    !$past(sys_rst) && !pwm_pin_ff.oe |-> !$past(gpio_oe) && pwm_pin_ff.out == $past(gpio_out);
  endproperty
  a_pin_gpio: assert property (p_pin_gpio)
    else $error("pin not following gpio");
  property p_tone_off;
    bus_req.wr && bus_req.addr == OFS_TONE_CTRL && !bus_req.wdata[TONE_EN_BIT]
      |-> ##2 !tone_out_ff [*2];
  endproperty
  a_tone_off: assert property (p_tone_off)
    else $error("tone active after disable");
endmodule // tpb_timer_chk

bind tpb_timer tpb_timer_chk u_tpb_timer_chk (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
  .ext_count_clock_pin(ext_count_clock_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
  .pwm_pin_ff(pwm_pin_ff), .tone_out_ff(tone_out_ff),
  .underflow_flag_ff(underflow_flag_ff), .underflow_irq_ff(underflow_irq_ff)
);

/* File: verification/tpb_ext_clk_model.sv */
`timescale 1ns/1ps
module tpb_ext_clk_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic [11:0] nedge,
  output logic             ext_pin_ff,
  output logic             busy
);
  logic [11:0] left_ff;
  logic        ph_ff;
  // Gated source: pin rests at its last level between bursts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_ff    <= 12'h000;
      ph_ff      <= 1'b0;
      ext_pin_ff <= 1'b0;
    end else if (go) begin
      left_ff <= nedge;
      ph_ff   <= 1'b0;
    end else if (left_ff != 12'h000) begin
      ph_ff <= ~ph_ff;
      if (ph_ff) begin
        ext_pin_ff <= ~ext_pin_ff;
        left_ff    <= left_ff - 12'h001;
      end
    end
  end
  assign busy = (left_ff != 12'h000);
endmodule // tpb_ext_clk_model

/* File: verification/tpb_timer_tb.sv */
`timescale 1ns/1ps
module tpb_timer_tb;
  import tpb_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  tpb_bus_req_t      bus_req = '0;
  logic              gpio_out = 1'b0;
  logic              gpio_oe = 1'b0;
  logic              go = 1'b0;
  logic [11:0]       nedge = '0;
  logic [DATA_W-1:0] rd_data_ff;
  tpb_pin_t          pwm_pin_ff;
  logic              tone_out_ff;
  logic              underflow_flag_ff;
  logic              underflow_irq_ff;
  logic              ext_pin;
  logic              busy;
  int                errors = 0;
  int                check_count = 0;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  rel;
  logic [CNT_W-1:0]  cv;
  logic [CNT_W-1:0]  duty = '0;
  logic [PS_W-1:0]   ps = 8'hff;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] c1;
  logic [DATA_W-1:0] c2;
  logic              flag = 1'b0;
  logic              ie = 1'b0;
  logic              lvl = 1'b0;
  logic              tone;
  logic [7:0]        ofs [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h19, 8'h20, 8'h07};
  logic [7:0]        rv [9] = '{8'h00, 8'h00, 8'h3f, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

  tpb_timer u_tpb_timer (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .ext_count_clock_pin(ext_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pwm_pin_ff(pwm_pin_ff), .tone_out_ff(tone_out_ff),
    .underflow_flag_ff(underflow_flag_ff), .underflow_irq_ff(underflow_irq_ff)
  );
  tpb_ext_clk_model u_tpb_ext_clk_model (
    .clk(clk), .sys_rst(sys_rst), .go(go), .nedge(nedge), .ext_pin_ff(ext_pin), .busy(busy)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rd_data_ff;
  endtask

  task automatic setc(input logic [9:0] v);
    wr(OFS_HIGH_BITS, {2'b00, v[9:8], 2'b00, duty[9:8]});
    wr(OFS_COUNT_LOW, v[7:0]);
    cnt = v;
    rel = v;
  endtask

  // Counting edges seen for t toggles from a resting level
  function automatic int evs(input logic l, input int t, input logic fall);
    return (l ^ fall) ? t / 2 : (t + 1) / 2;
  endfunction

  function automatic logic [9:0] step(input logic [9:0] c);
    if (c != 10'h000) return c - 10'h001;
    flag = 1'b1;
    if (c1[2]) return c;
    return c1[1] ? rel : CNT_WRAP;
  endfunction

  task automatic run(input int t);
    int e;
    int k;
    e = evs(lvl, t, c2[CTRL2_EDGE_BIT]);
    ps = ps - e[7:0];
    k = c2[CTRL2_PSDIS_BIT] ? e : e >> (c2[2:0] + 1);
    if (c1[0]) repeat (k) cnt = step(cnt);
    if (t[0]) lvl = ~lvl;
    @(posedge clk);
    go <= 1'b1;
    nedge <= t[11:0];
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 5000 && busy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    rd(OFS_COUNT_LOW);
    chk(cnt[7:0], d);
    rd(OFS_HIGH_BITS);
    chk(cnt[9:8], d[5:4]);
    rd(OFS_PS_VALUE);
    chk(ps, d);
    chk(flag, underflow_flag_ff);
    chk(flag & ie, underflow_irq_ff);
  endtask

  initial begin
    void'($urandom(46607));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(rv[i], d);
    end
    // External source, prescaler bypassed, modes and edges at random
    c2 = 8'h28;
    for (int i = 0; i < 16; i++) begin
      c1 = 8'($urandom) & 8'h07;
      c1[CTRL1_ENABLE_BIT] = (i % 4 != 3);
      c2[CTRL2_EDGE_BIT] = 1'($urandom);
      ie = 1'($urandom);
      flag = 1'b0;
      wr(OFS_FLAG_CTRL, {6'b0, ie, 1'b0});
      wr(OFS_CTRL_TWO, c2);
      wr(OFS_CTRL_ONE, c1);
      rd(OFS_CTRL_ONE);
      chk(c1, d);
      rd(OFS_CTRL_TWO);
      chk(c2, d);
      cv = (i < 4) ? 10'(i) : 10'($urandom);
      setc(cv);
      run($urandom_range(1, 12));
    end
    c1 = 8'h01;
    wr(OFS_CTRL_ONE, c1);
    setc(10'h3ff);
    tone = 1'b0;
    for (int r = 0; r < 8; r++) begin
      c2 = {5'b00101, r[2:0]};
      wr(OFS_CTRL_TWO, c2);
      c2[CTRL2_PSDIS_BIT] = 1'b0;
      wr(OFS_CTRL_TWO, c2);
      wr(OFS_TONE_CTRL, {5'b10000, r[2:0]});
      run(4 << r);
      tone = ~tone;
      chk(tone, tone_out_ff);
    end
    c2 = 8'h28;
    wr(OFS_CTRL_TWO, c2);
    for (int b = 0; b < 8; b++) begin
      setc(10'($urandom));
      wr(OFS_TONE_CTRL, 8'h88 | b[7:0]);
      repeat (3) @(posedge clk);
      chk(cnt[b], tone_out_ff);
    end
    wr(OFS_TONE_CTRL, 8'h08);
    repeat (3) @(posedge clk);
    chk(1'b0, tone_out_ff);
    for (int i = 0; i < 10; i++) begin
      cv = (i == 2) ? 10'h3fe : 10'($urandom);
      duty = (i == 0) ? cv : (i == 1) ? 10'h000 : (i == 2) ? 10'h3ff : 10'($urandom);
      setc(cv);
      wr(OFS_DUTY_LOW, duty[7:0]);
      c1 = {1'b1, 1'($urandom), 6'b0};
      wr(OFS_CTRL_ONE, c1);
      repeat (3) @(posedge clk);
      chk({1'b1, (cnt < duty) ^ c1[6]}, {pwm_pin_ff.oe, pwm_pin_ff.out});
    end
    wr(OFS_CTRL_ONE, 8'h00);
    repeat (6) begin
      @(posedge clk);
      gpio_out <= 1'($urandom);
      gpio_oe <= 1'($urandom);
      @(posedge clk);
      #1 chk({gpio_out, gpio_oe}, pwm_pin_ff);
    end
    // Enable stands for exactly two edges, so the count drops by two
    wr(OFS_CTRL_TWO, 8'h08);
    setc(10'h100);
    wr(OFS_CTRL_ONE, 8'h01);
    wr(OFS_CTRL_ONE, 8'h00);
    rd(OFS_COUNT_LOW);
    cv = 10'h100 - 10'h002;
    chk(cv[7:0], d);
    final_report();
  end

  // Generous margin over the few thousand cycles the sequence needs
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule // tpb_timer_tb
